// file: rtl/rtcv_pkg.sv
// shared constants, types and calendar helpers for the calendar value block
package rtcv_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // reference clock and calibration
    localparam int unsigned REF_HZ = 32768;
    localparam int unsigned CAL_STEP = 4;
    localparam int unsigned CAL_SHIFT = $clog2(CAL_STEP);

    ////////////////////////////////////////////////////////////////////////////////
    // register selector codes on the register port
    typedef logic [1:0] rtcv_sel_t;
    typedef logic [15:0] rtcv_word_t;
    localparam rtcv_sel_t SEL_CONFIG = 2'h0;
    localparam rtcv_sel_t SEL_VALUE_WIN = 2'h1;
    localparam rtcv_sel_t SEL_ALARM_WIN = 2'h2;
    localparam rtcv_sel_t SEL_ALARM_PTR = 2'h3;

    // window pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WKDY_HOUR = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;
    localparam logic [1:0] PTR_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration / trim register layout
    localparam int unsigned CFG_ENABLE_BIT = 15;
    localparam int unsigned CFG_UNLOCK_BIT = 13;
    localparam int unsigned CFG_HALF_BIT = 11;
    localparam int unsigned CFG_PTR_LSB = 8;
    localparam int unsigned CFG_TRIM_LSB = 0;
    localparam int unsigned ALARM_PTR_LSB = 8;
    localparam rtcv_word_t CFG_RESET = 16'h0000;
    localparam rtcv_word_t VALUE_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // implemented bits of each value register
    localparam rtcv_word_t YEAR_MASK = 16'h00ff;
    localparam rtcv_word_t MONTH_DAY_MASK = 16'h1f3f;
    localparam rtcv_word_t WKDY_HOUR_MASK = 16'h073f;
    localparam rtcv_word_t MIN_SEC_MASK = 16'h7f7f;

    // digit field positions
    localparam int unsigned SEC_LSB = 0;
    localparam int unsigned MIN_LSB = 8;
    localparam int unsigned HOUR_LSB = 0;
    localparam int unsigned WEEKDAY_CODE_LSB = 8;
    localparam int unsigned DAY_LSB = 0;
    localparam int unsigned MONTH_LSB = 8;
    localparam int unsigned YEAR_LSB = 0;

    // packed decimal limits
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [2:0] WEEKDAY_CODE_LAST = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // two-digit decimal step: {carry, next value}; wraps from last to first
    function automatic logic [8:0] rtcv_bcd_step(input logic [7:0] v, input logic [7:0] last,
                                                 input logic [7:0] first);
        logic [8:0] r;
        r = {1'b0, v};
        if (v == last) begin
            r = {1'b1, first};
        end else if (v[3:0] >= 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // last day of a month; leap rule is every fourth year of the century
    function automatic logic [7:0] rtcv_month_last(input logic [7:0] month,
                                                   input logic [7:0] year);
        logic leap;
        logic [7:0] r;
        leap = (!year[4] && (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8))
            || (year[4] && (year[3:0] == 4'h2 || year[3:0] == 4'h6));
        r = 8'h31;
        if (month == 8'h02) begin
            r = leap ? 8'h29 : 8'h28;
        end else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11) begin
            r = 8'h30;
        end
        return r;
    endfunction

    // byte-lane and field-masked write merge
    function automatic rtcv_word_t rtcv_merge(input rtcv_word_t old, input rtcv_word_t wdata,
                                              input logic [1:0] be, input rtcv_word_t fmask);
        rtcv_word_t m;
        m = {{8{be[1]}}, {8{be[0]}}} & fmask;
        return (old & ~m & fmask) | (wdata & m);
    endfunction

endpackage

// file: rtl/rtcv_tick_if.sv
// signals between the register/calendar logic and the reference prescaler
`timescale 1ns/1ns
interface rtcv_tick_if;
    logic enable;
    logic restart;
    logic at_minute_end;
    logic [7:0] trim;
    logic sec_tick;
    logic half_tick;

    modport ctrl (output enable, output restart, output at_minute_end, output trim,
                  input sec_tick, input half_tick);
    modport timer (input enable, input restart, input at_minute_end, input trim,
                   output sec_tick, output half_tick);
endinterface

// file: rtl/rtcv_prescale.sv
// reference clock prescaler with once-a-minute drift trim
`timescale 1ns/1ns
module rtcv_prescale #(
    parameter int unsigned REF_HZ = rtcv_pkg::REF_HZ
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ref_clk,
    rtcv_tick_if.timer tick
);
    import rtcv_pkg::*;

    localparam int unsigned PW = $clog2(REF_HZ) + 2;
    localparam logic signed [PW-1:0] TOP = PW'(REF_HZ - 1);
    localparam logic signed [PW-1:0] HALF_M1 = PW'(REF_HZ / 2 - 1);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic signed [PW-1:0] pre;
        logic sec;
        logic half;
    } rtcv_pre_s;

    rtcv_pre_s q_r;
    rtcv_pre_s q_nxt;
    logic signed [PW-1:0] trim_cnt;

    // trim scaled by four, sign extended; negative start lengthens the second
    assign trim_cnt = {{(PW - 8 - CAL_SHIFT){tick.trim[7]}}, tick.trim, {CAL_SHIFT{1'b0}}};

    ////////////////////////////////////////////////////////////////////////////////
    // sync the crystal, count its rising edges
    always_comb begin
        q_nxt = q_r;
        q_nxt.sync1 = i_ref_clk;
        q_nxt.sync2 = q_r.sync1;
        q_nxt.sync3 = q_r.sync2;
        q_nxt.sec = 1'b0;
        q_nxt.half = 1'b0;
        if (tick.restart) begin
            q_nxt.pre = '0;
        end else if (tick.enable && q_r.sync2 && !q_r.sync3) begin
            if (q_r.pre >= TOP) begin
                q_nxt.sec = 1'b1;
                // start of a new minute picks up the trim offset
                q_nxt.pre = tick.at_minute_end ? trim_cnt : '0;
            end else begin
                q_nxt.pre = q_r.pre + PW'(1);
                q_nxt.half = (q_r.pre == HALF_M1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tick.sec_tick = q_r.sec;
    assign tick.half_tick = q_r.half;

endmodule

// file: rtl/rtcv_calendar.sv
// calendar, alarm value registers and drift-trim control behind a pointer window
//
// How it works
// - year holds tens digit in bits 7-4, ones in 3-0, each 0-9
// - unimplemented upper value bits always read as zero
// - year writes taken only while write unlock is set
// - month/day: month tens bit 12, ones 11-8, day tens 5-4, ones 3-0
// - weekday 0-6 in bits 10-8, hour tens 5-4, hour ones 3-0
// - minute tens 14-12, minute ones 11-8, second tens 6-4, ones 3-0
// - month/day and weekday/hour writes need write unlock set
// - time fields advance by hardware, read and written by software
// - alarm registers share time digit layout, plain storage
// - alarm month/day and weekday/hour writes need write unlock set
// - signed eight-bit trim times four pulses applied once per minute
// - positive trim adds pulses, negative removes, four per step
// - window pointer picks register, counts down on any read or high-byte write, stops at 00
// - half-second flag clears when minutes/seconds low byte is written
`timescale 1ns/1ns
module rtcv_calendar (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ref_clk,
    input wire rtcv_pkg::rtcv_sel_t i_reg_sel,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [1:0] i_reg_be,
    input wire rtcv_pkg::rtcv_word_t i_reg_wdata,
    output rtcv_pkg::rtcv_word_t o_reg_rdata,
    output logic o_half_second,
    output logic o_second_pulse
);
    import rtcv_pkg::*;

    typedef struct packed {
        rtcv_word_t year;
        rtcv_word_t month_day;
        rtcv_word_t wkdy_hour;
        rtcv_word_t min_sec;
        rtcv_word_t al_month_day;
        rtcv_word_t al_wkdy_hour;
        rtcv_word_t al_min_sec;
        logic timer_enable;
        logic value_write_unlock;
        logic half_second_flag;
        logic [1:0] value_window_pointer;
        logic [1:0] alarm_window_pointer;
        logic [7:0] trim;
        rtcv_word_t rdata;
        logic sec_pulse;
    } rtcv_regs_s;

    rtcv_regs_s q_r;
    rtcv_regs_s q_nxt;

    rtcv_tick_if tk ();

    logic cfg_wr;
    logic win_wr;
    logic win_rd;
    logic al_wr;
    logic al_rd;
    logic aptr_wr;
    logic sec_low_wr;
    rtcv_word_t cfg_word;

    ////////////////////////////////////////////////////////////////////////////////
    // register port decode
    always_comb begin
        cfg_wr = 1'b0;
        win_wr = 1'b0;
        win_rd = 1'b0;
        al_wr = 1'b0;
        al_rd = 1'b0;
        aptr_wr = 1'b0;
        if (i_reg_sel == SEL_CONFIG) begin
            cfg_wr = i_reg_wr;
        end else if (i_reg_sel == SEL_VALUE_WIN) begin
            win_wr = i_reg_wr;
            win_rd = i_reg_rd;
        end else if (i_reg_sel == SEL_ALARM_WIN) begin
            al_wr = i_reg_wr;
            al_rd = i_reg_rd;
        end else begin
            aptr_wr = i_reg_wr;
        end
    end

    // any write attempt to the seconds byte clears the half flag and realigns the prescaler
    assign sec_low_wr = win_wr && i_reg_be[0] && (q_r.value_window_pointer == PTR_MIN_SEC);

    // configuration word as software sees it; unnamed bits read zero
    always_comb begin
        cfg_word = CFG_RESET;
        cfg_word[CFG_ENABLE_BIT] = q_r.timer_enable;
        cfg_word[CFG_UNLOCK_BIT] = q_r.value_write_unlock;
        cfg_word[CFG_HALF_BIT] = q_r.half_second_flag;
        cfg_word[CFG_PTR_LSB +: 2] = q_r.value_window_pointer;
        cfg_word[CFG_TRIM_LSB +: 8] = q_r.trim;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler link
    assign tk.enable = q_r.timer_enable;
    assign tk.trim = q_r.trim;
    assign tk.restart = sec_low_wr;
    assign tk.at_minute_end = (q_r.min_sec[SEC_LSB +: 7] == SEC_LAST[6:0]);

    rtcv_prescale #(
        .REF_HZ(REF_HZ)
    ) u_prescale (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ref_clk(i_ref_clk),
        .tick(tk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state: calendar advance, then software writes on top
    always_comb begin
        logic [8:0] st_sec;
        logic [8:0] st_min;
        logic [8:0] st_hour;
        logic [8:0] st_day;
        logic [8:0] st_month;
        logic [8:0] st_year;
        st_sec = '0;
        st_min = '0;
        st_hour = '0;
        st_day = '0;
        st_month = '0;
        st_year = '0;
        q_nxt = q_r;
        q_nxt.sec_pulse = tk.sec_tick;

        // ripple carry from seconds up to the year
        if (tk.sec_tick) begin
            st_sec = rtcv_bcd_step({1'b0, q_r.min_sec[SEC_LSB +: 7]}, SEC_LAST, BCD_ZERO);
            q_nxt.min_sec[SEC_LSB +: 7] = st_sec[6:0];
            if (st_sec[8]) begin
                st_min = rtcv_bcd_step({1'b0, q_r.min_sec[MIN_LSB +: 7]}, MIN_LAST, BCD_ZERO);
                q_nxt.min_sec[MIN_LSB +: 7] = st_min[6:0];
            end
            if (st_sec[8] && st_min[8]) begin
                st_hour = rtcv_bcd_step({2'b00, q_r.wkdy_hour[HOUR_LSB +: 6]}, HOUR_LAST,
                                        BCD_ZERO);
                q_nxt.wkdy_hour[HOUR_LSB +: 6] = st_hour[5:0];
            end
            if (st_sec[8] && st_min[8] && st_hour[8]) begin
                // weekday counts 0..6 and wraps
                if (q_r.wkdy_hour[WEEKDAY_CODE_LSB +: 3] >= WEEKDAY_CODE_LAST) begin
                    q_nxt.wkdy_hour[WEEKDAY_CODE_LSB +: 3] = 3'h0;
                end else begin
                    q_nxt.wkdy_hour[WEEKDAY_CODE_LSB +: 3] = q_r.wkdy_hour[WEEKDAY_CODE_LSB +: 3] + 3'h1;
                end
                st_day = rtcv_bcd_step({2'b00, q_r.month_day[DAY_LSB +: 6]},
                                       rtcv_month_last({3'b000, q_r.month_day[MONTH_LSB +: 5]},
                                                       q_r.year[YEAR_LSB +: 8]),
                                       BCD_ONE);
                q_nxt.month_day[DAY_LSB +: 6] = st_day[5:0];
            end
            if (st_sec[8] && st_min[8] && st_hour[8] && st_day[8]) begin
                st_month = rtcv_bcd_step({3'b000, q_r.month_day[MONTH_LSB +: 5]}, MONTH_LAST,
                                         BCD_ONE);
                q_nxt.month_day[MONTH_LSB +: 5] = st_month[4:0];
            end
            if (st_sec[8] && st_min[8] && st_hour[8] && st_day[8] && st_month[8]) begin
                st_year = rtcv_bcd_step(q_r.year[YEAR_LSB +: 8], YEAR_LAST, BCD_ZERO);
                q_nxt.year[YEAR_LSB +: 8] = st_year[7:0];
            end
        end

        // half-second flag: the set wins over a clear in the same cycle
        if (tk.sec_tick || sec_low_wr) begin
            q_nxt.half_second_flag = 1'b0;
        end
        if (tk.half_tick) begin
            q_nxt.half_second_flag = 1'b1;
        end

        // configuration writes; enable changes only once unlocked
        if (cfg_wr) begin
            if (i_reg_be[0]) begin
                q_nxt.trim = i_reg_wdata[CFG_TRIM_LSB +: 8];
            end
            if (i_reg_be[1]) begin
                q_nxt.value_write_unlock = i_reg_wdata[CFG_UNLOCK_BIT];
                q_nxt.value_window_pointer = i_reg_wdata[CFG_PTR_LSB +: 2];
                if (q_r.value_write_unlock) begin
                    q_nxt.timer_enable = i_reg_wdata[CFG_ENABLE_BIT];
                end
            end
        end
        if (aptr_wr && i_reg_be[1]) begin
            q_nxt.alarm_window_pointer = i_reg_wdata[ALARM_PTR_LSB +: 2];
        end

        // time window writes, all locked without unlock; a write beats the tick
        if (win_wr && q_r.value_write_unlock) begin
            if (q_r.value_window_pointer == PTR_YEAR) begin
                q_nxt.year = rtcv_merge(q_nxt.year, i_reg_wdata, i_reg_be, YEAR_MASK);
            end else if (q_r.value_window_pointer == PTR_MONTH_DAY) begin
                q_nxt.month_day = rtcv_merge(q_nxt.month_day, i_reg_wdata, i_reg_be,
                                             MONTH_DAY_MASK);
            end else if (q_r.value_window_pointer == PTR_WKDY_HOUR) begin
                q_nxt.wkdy_hour = rtcv_merge(q_nxt.wkdy_hour, i_reg_wdata, i_reg_be,
                                             WKDY_HOUR_MASK);
            end else begin
                q_nxt.min_sec = rtcv_merge(q_nxt.min_sec, i_reg_wdata, i_reg_be,
                                           MIN_SEC_MASK);
            end
        end

        // alarm window writes; only the upper two need unlock
        if (al_wr) begin
            if (q_r.alarm_window_pointer == PTR_MIN_SEC) begin
                q_nxt.al_min_sec = rtcv_merge(q_r.al_min_sec, i_reg_wdata, i_reg_be,
                                              MIN_SEC_MASK);
            end else if (q_r.alarm_window_pointer == PTR_WKDY_HOUR && q_r.value_write_unlock) begin
                q_nxt.al_wkdy_hour = rtcv_merge(q_r.al_wkdy_hour, i_reg_wdata, i_reg_be,
                                                WKDY_HOUR_MASK);
            end else if (q_r.alarm_window_pointer == PTR_MONTH_DAY && q_r.value_write_unlock) begin
                q_nxt.al_month_day = rtcv_merge(q_r.al_month_day, i_reg_wdata, i_reg_be,
                                                MONTH_DAY_MASK);
            end
        end

        // pointer steps down on any read or a high-byte write, stops at 00
        if ((win_rd || (win_wr && i_reg_be[1])) && q_r.value_window_pointer != PTR_MIN_SEC) begin
            q_nxt.value_window_pointer = q_r.value_window_pointer - 2'h1;
        end
        if ((al_rd || (al_wr && i_reg_be[1])) && q_r.alarm_window_pointer != PTR_MIN_SEC) begin
            q_nxt.alarm_window_pointer = q_r.alarm_window_pointer - 2'h1;
        end

        // read data registered; stored values never hold unimplemented bits
        if (i_reg_rd) begin
            q_nxt.rdata = VALUE_RESET;
            if (i_reg_sel == SEL_CONFIG) begin
                q_nxt.rdata = cfg_word;
            end else if (i_reg_sel == SEL_VALUE_WIN) begin
                if (q_r.value_window_pointer == PTR_YEAR) begin
                    q_nxt.rdata = q_r.year & YEAR_MASK;
                end else if (q_r.value_window_pointer == PTR_MONTH_DAY) begin
                    q_nxt.rdata = q_r.month_day & MONTH_DAY_MASK;
                end else if (q_r.value_window_pointer == PTR_WKDY_HOUR) begin
                    q_nxt.rdata = q_r.wkdy_hour & WKDY_HOUR_MASK;
                end else begin
                    q_nxt.rdata = q_r.min_sec & MIN_SEC_MASK;
                end
            end else if (i_reg_sel == SEL_ALARM_WIN) begin
                if (q_r.alarm_window_pointer == PTR_MONTH_DAY) begin
                    q_nxt.rdata = q_r.al_month_day;
                end else if (q_r.alarm_window_pointer == PTR_WKDY_HOUR) begin
                    q_nxt.rdata = q_r.al_wkdy_hour;
                end else if (q_r.alarm_window_pointer == PTR_MIN_SEC) begin
                    q_nxt.rdata = q_r.al_min_sec;
                end
            end else begin
                q_nxt.rdata[ALARM_PTR_LSB +: 2] = q_r.alarm_window_pointer;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; value registers clear too, which software may not rely on
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_reg_rdata = q_r.rdata;
    assign o_half_second = q_r.half_second_flag;
    assign o_second_pulse = q_r.sec_pulse;

endmodule

// file: sim/rtcv_calendar_asserts.sv
// port-level checks of the calendar value block
`timescale 1ns/1ns
module rtcv_calendar_asserts
    import rtcv_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ref_clk,
    input wire rtcv_pkg::rtcv_sel_t i_reg_sel,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [1:0] i_reg_be,
    input wire rtcv_pkg::rtcv_word_t i_reg_wdata,
    input wire rtcv_pkg::rtcv_word_t o_reg_rdata,
    input wire logic o_half_second,
    input wire logic o_second_pulse
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the config fields, rebuilt from the port traffic alone
    logic [1:0] ptr_r;
    logic unl_r;
    logic en_r;
    logic [7:0] trim_r;
    rtcv_word_t win_mask;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ptr_r <= PTR_RESET;
            unl_r <= 1'b0;
            en_r <= 1'b0;
            trim_r <= 8'h00;
        end else if (i_reg_wr && i_reg_sel == SEL_CONFIG) begin
            if (i_reg_be[1]) begin
                ptr_r <= i_reg_wdata[9:8];
                unl_r <= i_reg_wdata[13];
                // enable follows only an earlier unlock
                en_r <= unl_r ? i_reg_wdata[15] : en_r;
            end
            if (i_reg_be[0]) begin
                trim_r <= i_reg_wdata[7:0];
            end
        end else if (i_reg_sel == SEL_VALUE_WIN && (i_reg_rd || (i_reg_wr && i_reg_be[1]))
                     && ptr_r != PTR_MIN_SEC) begin
            ptr_r <= ptr_r - 2'h1;
        end
    end

    // implemented bits of the register under the pointer
    always_comb begin
        case (ptr_r)
            PTR_MIN_SEC: win_mask = MIN_SEC_MASK;
            PTR_WKDY_HOUR: win_mask = WKDY_HOUR_MASK;
            PTR_MONTH_DAY: win_mask = MONTH_DAY_MASK;
            default: win_mask = YEAR_MASK;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    a_pulse_single: assert property (o_second_pulse |=> !o_second_pulse)
        else $error("second pulse longer than one cycle");
    a_pulse_half_low: assert property (o_second_pulse |-> !o_half_second)
        else $error("half flag high at the second pulse");
    a_half_clear: assert property (
        i_reg_wr && i_reg_sel == SEL_VALUE_WIN && i_reg_be[0] && ptr_r == PTR_MIN_SEC
        |=> !o_half_second)
        else $error("half flag not cleared by seconds write");
    a_window_masks: assert property (
        i_reg_rd && i_reg_sel == SEL_VALUE_WIN |=> (o_reg_rdata & ~$past(win_mask)) == 16'h0000)
        else $error("unimplemented value bit read as one");
    a_cfg_pointer: assert property (
        i_reg_rd && i_reg_sel == SEL_CONFIG |=> o_reg_rdata[9:8] == $past(ptr_r))
        else $error("window pointer readback wrong");
    a_cfg_lock: assert property (
        i_reg_rd && i_reg_sel == SEL_CONFIG
        |=> {o_reg_rdata[15], o_reg_rdata[13]} == {$past(en_r), $past(unl_r)})
        else $error("enable or unlock readback wrong");
    a_cfg_trim: assert property (
        i_reg_rd && i_reg_sel == SEL_CONFIG |=> o_reg_rdata[7:0] == $past(trim_r))
        else $error("trim readback wrong");
    a_cfg_half: assert property (
        i_reg_rd && i_reg_sel == SEL_CONFIG |=> o_reg_rdata[11] == $past(o_half_second))
        else $error("half flag readback wrong");
endmodule

bind rtcv_calendar rtcv_calendar_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_ref_clk(i_ref_clk), .i_reg_sel(i_reg_sel), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
    .i_reg_be(i_reg_be), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_half_second(o_half_second), .o_second_pulse(o_second_pulse));

// file: sim/rtcv_calendar_test.sv
// directed register and timekeeping test of the calendar value block
`timescale 1ns/1ns
module rtcv_calendar_test;
    import rtcv_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ref_clk = 1'b0;
    rtcv_sel_t i_reg_sel = SEL_CONFIG;
    logic i_reg_rd = 1'b0;
    logic i_reg_wr = 1'b0;
    logic [1:0] i_reg_be = 2'h0;
    rtcv_word_t i_reg_wdata = 16'h0000;
    rtcv_word_t o_reg_rdata;
    logic o_half_second;
    logic o_second_pulse;
    logic ref_run = 1'b0;
    int bad_count = 0;
    int comparisons = 0;
    localparam rtcv_word_t TW[4] = '{16'hff99, 16'hf231, 16'hfe23, 16'hd959};
    localparam rtcv_word_t TE[4] = '{16'h0099, 16'h1231, 16'h0623, 16'h5959};
    localparam rtcv_word_t AW[3] = '{16'hf112, 16'hf905, 16'hc530};
    localparam rtcv_word_t AE[4] = '{16'h0000, 16'h1112, 16'h0105, 16'h0102};

    rtcv_calendar DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ref_clk(i_ref_clk),
        .i_reg_sel(i_reg_sel), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_be(i_reg_be),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_half_second(o_half_second),
        .o_second_pulse(o_second_pulse));

    ////////////////////////////////////////////////////////////////////////////////
    always #5 i_clk = ~i_clk;

    // fast reference: one edge per two cycles keeps a second near 65k cycles
    always @(negedge i_clk) begin
        if (ref_run) begin
            i_ref_clk <= ~i_ref_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input rtcv_word_t exp, input rtcv_word_t got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_range(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    // strobe for one cycle, then one idle cycle before the next access
    task automatic reg_wr(input rtcv_sel_t sel, input logic [1:0] be, input rtcv_word_t data);
        @(negedge i_clk);
        i_reg_sel = sel;
        i_reg_be = be;
        i_reg_wdata = data;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask

    task automatic reg_rd(input rtcv_sel_t sel, input rtcv_word_t exp);
        @(negedge i_clk);
        i_reg_sel = sel;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        chk_word(exp, o_reg_rdata);
    endtask

    // half a second apart: flag rise, then the pulse; a run-out ends the test
    task automatic wait_high(input bit pulse, input int lo, input int hi);
        int n;
        n = 0;
        while ((pulse ? o_second_pulse : o_half_second) !== 1'b1 && n < 40000) begin
            @(negedge i_clk);
            n++;
        end
        chk_range(n, lo, hi);
        if (n >= 40000) begin
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge i_clk);
        i_rst = 1'b0;
        reg_rd(SEL_CONFIG, CFG_RESET);
        // locked: enable refused, pointer still loads and counts down
        reg_wr(SEL_CONFIG, 2'h3, 16'h8300);
        reg_rd(SEL_CONFIG, 16'h0300);
        reg_wr(SEL_VALUE_WIN, 2'h3, 16'h0055);
        reg_rd(SEL_CONFIG, 16'h0200);
        reg_wr(SEL_CONFIG, 2'h3, 16'h0300);
        reg_rd(SEL_VALUE_WIN, VALUE_RESET);
        // trim 5: crystal 20 pulses a minute slow, loaded while the timer is off
        reg_wr(SEL_CONFIG, 2'h3, 16'h2305);
        for (int i = 0; i < 4; i++) begin
            reg_wr(SEL_VALUE_WIN, 2'h3, TW[i]);
        end
        reg_wr(SEL_CONFIG, 2'h3, 16'ha305);
        reg_rd(SEL_CONFIG, 16'ha305);
        for (int i = 0; i < 4; i++) begin
            reg_rd(SEL_VALUE_WIN, TE[i]);
        end
        reg_rd(SEL_CONFIG, 16'ha005);
        // alarm storage, then locked writes that only pointer 0 takes
        reg_wr(SEL_ALARM_PTR, 2'h3, 16'h0200);
        for (int i = 0; i < 3; i++) begin
            reg_wr(SEL_ALARM_WIN, 2'h3, AW[i]);
        end
        // timer is on now: upper byte only, so the trim is left alone
        reg_wr(SEL_CONFIG, 2'h2, 16'h8200);
        reg_wr(SEL_ALARM_PTR, 2'h3, 16'h0200);
        for (int i = 0; i < 3; i++) begin
            reg_wr(SEL_ALARM_WIN, 2'h3, 16'h0102);
        end
        reg_wr(SEL_ALARM_PTR, 2'h3, 16'h0300);
        for (int i = 0; i < 4; i++) begin
            reg_rd(SEL_ALARM_WIN, AE[i]);
        end
        // one second from 00:59 restarts the prescaler and carries a minute
        reg_wr(SEL_CONFIG, 2'h2, 16'ha000);
        ref_run = 1'b1;
        reg_wr(SEL_VALUE_WIN, 2'h3, 16'h0059);
        wait_high(1'b0, 32755, 32800);
        wait_high(1'b1, 32755, 32800);
        reg_rd(SEL_VALUE_WIN, 16'h0100);
        reg_rd(SEL_CONFIG, 16'ha005);
        // second after :59 starts 4*5 edges in, so its half comes 40 cycles early
        wait_high(1'b0, 32716, 32732);
        reg_rd(SEL_CONFIG, 16'ha805);
        // clear the raised flag by a seconds-byte write
        reg_wr(SEL_VALUE_WIN, 2'h1, 16'h0000);
        reg_rd(SEL_CONFIG, 16'ha005);
        end_of_test();
    end
endmodule
